// File: core/tmr_pkg.sv
// package: register map, field layout, encodings and carrier types of the timer block
package tmr_pkg;

  // register index inside one instance; byte address is base + 4 * index
  localparam logic [2:0] TMR_IDX_CTRL0   = 3'h0;
  localparam logic [2:0] TMR_IDX_CTRL1   = 3'h1;
  localparam logic [2:0] TMR_IDX_CNT_LO  = 3'h2;
  localparam logic [2:0] TMR_IDX_CNT_HI  = 3'h3;
  localparam logic [2:0] TMR_IDX_CMPA_LO = 3'h4;
  localparam logic [2:0] TMR_IDX_CMPA_HI = 3'h5;
  localparam logic [2:0] TMR_IDX_PERIOD  = 3'h6;

  // address layout: bits 4..2 index, bit 5 instance, bits 7..6 must be zero
  localparam int unsigned TMR_ADR_IDX_LSB  = 2;
  localparam int unsigned TMR_ADR_INST_BIT = 5;
  localparam int unsigned TMR_ADR_TOP_LSB  = 6;
  localparam logic [7:0]  TMR_INST1_BASE   = 8'h20;

  // control zero fields
  localparam int unsigned TMR_C0_PAUSE  = 7;
  localparam int unsigned TMR_C0_CK_LSB = 4;
  localparam int unsigned TMR_C0_RUN    = 3;
  localparam logic [7:0]  TMR_C0_WIDE_MASK = 8'hF8;

  // control one fields
  localparam int unsigned TMR_C1_MODE_LSB = 6;
  localparam int unsigned TMR_C1_FUNC_LSB = 4;
  localparam int unsigned TMR_C1_INIT     = 3;
  localparam int unsigned TMR_C1_INVERT   = 2;
  localparam int unsigned TMR_C1_SWAP     = 1;
  localparam int unsigned TMR_C1_CLRSEL   = 0;

  localparam logic [7:0]  TMR_REG_RST = 8'h00;
  localparam logic [31:0] TMR_RD_NONE = 32'h0000_0000;

  // prescaler counts
  localparam int unsigned TMR_SYS_DIV  = 4;
  localparam int unsigned TMR_HIGH_DIV_A = 16;
  localparam int unsigned TMR_HIGH_DIV_B = 64;

  typedef enum logic [1:0] {
    TMR_MODE_CMP = 2'b00,
    TMR_MODE_CAP = 2'b01,
    TMR_MODE_PWM = 2'b10,
    TMR_MODE_TMR = 2'b11
  } tmr_mode_t;

  // clock source codes
  localparam logic [2:0] TMR_CK_SYS4  = 3'h0;
  localparam logic [2:0] TMR_CK_SYS   = 3'h1;
  localparam logic [2:0] TMR_CK_HIGH16 = 3'h2;
  localparam logic [2:0] TMR_CK_HIGH64 = 3'h3;
  localparam logic [2:0] TMR_CK_SUB_A = 3'h4;
  localparam logic [2:0] TMR_CK_SUB_B = 3'h5;
  localparam logic [2:0] TMR_CK_EXT_R = 3'h6;
  localparam logic [2:0] TMR_CK_EXT_F = 3'h7;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } tmr_wb_req_t;

  typedef struct packed {
    logic sys4;
    logic sys;
    logic high16;
    logic high64;
    logic sub;
  } tmr_ticks_t;

endpackage

// File: core/tmr_top.sv
// timer block: two count-up timer instances behind a classic wishbone slave
`timescale 1ns/10ps

module tmr_chan #(
  parameter int unsigned CW     = 16,
  parameter int unsigned PW     = 8,
  parameter bit          HAS_RP = 1'b1
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst_b,
  input  wire tmr_pkg::tmr_ticks_t    ticks,
  input  wire logic                   ext_pin,
  input  wire logic                   cap_pin,
  input  wire logic                   acc,
  input  wire logic                   we,
  input  wire logic [2:0]             idx,
  input  wire logic [7:0]             wdat,
  output logic      [7:0]             rdat,
  output logic                        wave_ff,
  output logic                        oe_ff,
  output logic                        match_a_ff,
  output logic                        match_p_ff
);
  import tmr_pkg::*;

  logic [7:0]    c0_ff;
  logic [7:0]    c1_ff;
  logic [7:0]    rp_ff;
  logic [7:0]    buf_ff;
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] compare_value_a_ff;
  logic          run_q_ff;
  logic          lvl_ff;
  logic          pulse_ff;
  logic          ext_s1_ff, ext_s2_ff, ext_s3_ff;
  logic          cap_s1_ff, cap_s2_ff, cap_s3_ff;

  logic          run, pau, run_rise, tick, counting, hit_a, hit_p, clr, p_evt;
  logic          cap_evt, duty_on, nxt_lvl;
  logic [CW-1:0] nxt_cnt;
  logic [15:0]   cnt16, ccra16;
  logic [PW-1:0] prd;
  logic [2:0]    ck;
  logic [1:0]    func;
  tmr_mode_t     mode;

  assign run    = c0_ff[TMR_C0_RUN];
  assign pau    = c0_ff[TMR_C0_PAUSE];
  assign ck     = c0_ff[TMR_C0_CK_LSB +: 3];
  assign mode   = tmr_mode_t'(c1_ff[TMR_C1_MODE_LSB +: 2]);
  assign func   = c1_ff[TMR_C1_FUNC_LSB +: 2];
  assign cnt16  = 16'(cnt_ff);
  assign ccra16 = 16'(compare_value_a_ff);
  assign prd    = HAS_RP ? rp_ff[PW-1:0] : c0_ff[PW-1:0];
  assign run_rise = run & ~run_q_ff;

  // external pins pass three flops; only the second and third feed edge logic
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      {ext_s1_ff, ext_s2_ff, ext_s3_ff} <= 3'h0;
      {cap_s1_ff, cap_s2_ff, cap_s3_ff} <= 3'h0;
    end else begin
      {ext_s1_ff, ext_s2_ff, ext_s3_ff} <= {ext_pin, ext_s1_ff, ext_s2_ff};
      {cap_s1_ff, cap_s2_ff, cap_s3_ff} <= {cap_pin, cap_s1_ff, cap_s2_ff};
    end
  end

  always_comb begin
    case (ck)
      TMR_CK_SYS4:   tick = ticks.sys4;
      TMR_CK_SYS:    tick = ticks.sys;
      TMR_CK_HIGH16: tick = ticks.high16;
      TMR_CK_HIGH64: tick = ticks.high64;
      TMR_CK_SUB_A,
      TMR_CK_SUB_B:  tick = ticks.sub;
      TMR_CK_EXT_R:  tick = ext_s2_ff & ~ext_s3_ff;
      TMR_CK_EXT_F:  tick = ~ext_s2_ff & ext_s3_ff;
      default:       tick = 1'b0;
    endcase
  end

  always_comb begin
    case (func)
      2'b00:   cap_evt = cap_s2_ff & ~cap_s3_ff;
      2'b01:   cap_evt = ~cap_s2_ff & cap_s3_ff;
      2'b10:   cap_evt = cap_s2_ff ^ cap_s3_ff;
      default: cap_evt = 1'b0;
    endcase
    cap_evt = cap_evt & (mode == TMR_MODE_CAP) & run;
  end

  assign counting = run & ~pau & tick & ~run_rise;
  assign nxt_cnt  = cnt_ff + CW'(1);
  assign hit_a    = counting & (nxt_cnt == compare_value_a_ff);
  // a zero period code matches only when the counter wraps to zero
  assign hit_p    = counting & ((prd != '0) ?
                    (nxt_cnt[CW-1 -: PW] == prd && nxt_cnt[CW-PW-1:0] == '0) :
                    (nxt_cnt == '0));

  always_comb begin
    case (mode)
      TMR_MODE_PWM: clr = c1_ff[TMR_C1_SWAP] ? hit_a : hit_p;
      TMR_MODE_CAP: clr = hit_p;
      default:      clr = c1_ff[TMR_C1_CLRSEL] ? hit_a : hit_p;
    endcase
  end

  // with A selected as clear source no P event is reported in compare/timer modes
  assign p_evt = hit_p & ~(c1_ff[TMR_C1_CLRSEL] &
                 (mode == TMR_MODE_CMP || mode == TMR_MODE_TMR));

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cnt_ff   <= '0;
      run_q_ff <= 1'b0;
    end else begin
      run_q_ff <= run;
      if (run_rise)
        cnt_ff <= '0;
      else if (counting && clr)
        cnt_ff <= '0;
      else if (counting)
        cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      match_a_ff <= 1'b0;
      match_p_ff <= 1'b0;
    end else begin
      match_a_ff <= hit_a;
      match_p_ff <= p_evt;
    end
  end

  // register writes and the shared low-byte buffer
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      c0_ff   <= TMR_REG_RST;
      c1_ff   <= TMR_REG_RST;
      rp_ff   <= TMR_REG_RST;
      buf_ff  <= TMR_REG_RST;
      compare_value_a_ff <= '0;
    end else begin
      if (acc && we) begin
        case (idx)
          TMR_IDX_CTRL0:   c0_ff <= HAS_RP ? (wdat & TMR_C0_WIDE_MASK) : wdat;
          TMR_IDX_CTRL1:   c1_ff <= wdat;
          TMR_IDX_CMPA_LO: buf_ff <= wdat;
          TMR_IDX_CMPA_HI: compare_value_a_ff <= CW'({wdat, buf_ff});
          TMR_IDX_PERIOD:  rp_ff <= HAS_RP ? wdat : TMR_REG_RST;
          default: ;
        endcase
      end else if (acc) begin
        if (idx == TMR_IDX_CNT_HI)
          buf_ff <= cnt16[7:0];
        else if (idx == TMR_IDX_CMPA_HI)
          buf_ff <= ccra16[7:0];
      end
      // a bus write to the compare high byte wins over a capture in the same cycle
      if (cap_evt && !(acc && we && idx == TMR_IDX_CMPA_HI))
        compare_value_a_ff <= cnt_ff;
    end
  end

  always_comb begin
    case (idx)
      TMR_IDX_CTRL0:   rdat = c0_ff;
      TMR_IDX_CTRL1:   rdat = c1_ff;
      TMR_IDX_CNT_LO:  rdat = buf_ff;
      TMR_IDX_CNT_HI:  rdat = cnt16[15:8];
      TMR_IDX_CMPA_LO: rdat = buf_ff;
      TMR_IDX_CMPA_HI: rdat = ccra16[15:8];
      TMR_IDX_PERIOD:  rdat = HAS_RP ? rp_ff : TMR_REG_RST;
      default:         rdat = TMR_REG_RST;
    endcase
  end

  // pwm duty: compare A is duty unless the swap bit hands duty to the period code
  assign duty_on = c1_ff[TMR_C1_SWAP] ? (cnt_ff[CW-1 -: PW] < prd) : (cnt_ff < compare_value_a_ff);

  always_comb begin
    nxt_lvl = lvl_ff;
    case (mode)
      TMR_MODE_CMP: begin
        if (run_rise)
          nxt_lvl = c1_ff[TMR_C1_INIT];
        else if (hit_a) begin
          case (func)
            2'b01:   nxt_lvl = 1'b0;
            2'b10:   nxt_lvl = 1'b1;
            2'b11:   nxt_lvl = ~lvl_ff;
            default: nxt_lvl = lvl_ff;
          endcase
        end
      end
      TMR_MODE_PWM: begin
        case (func)
          2'b00:   nxt_lvl = ~c1_ff[TMR_C1_INIT];
          2'b01:   nxt_lvl = c1_ff[TMR_C1_INIT];
          2'b10:   nxt_lvl = (run && duty_on) ? c1_ff[TMR_C1_INIT] : ~c1_ff[TMR_C1_INIT];
          default: nxt_lvl = pulse_ff ? c1_ff[TMR_C1_INIT] : ~c1_ff[TMR_C1_INIT];
        endcase
      end
      default: nxt_lvl = lvl_ff;
    endcase
  end

  // single pulse: active from the run rise to the next A match
  always_ff @(posedge core_clk) begin
    if (!rst_b)
      pulse_ff <= 1'b0;
    else if (run_rise)
      pulse_ff <= 1'b1;
    else if (hit_a || !run)
      pulse_ff <= 1'b0;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      lvl_ff  <= 1'b0;
      wave_ff <= 1'b0;
      oe_ff   <= 1'b0;
    end else begin
      lvl_ff  <= nxt_lvl;
      // pin follows one cycle behind the level; inversion is off in timer mode
      wave_ff <= lvl_ff ^ (c1_ff[TMR_C1_INVERT] & (mode != TMR_MODE_TMR));
      oe_ff   <= (mode == TMR_MODE_CMP) || (mode == TMR_MODE_PWM);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  run_clear_a: assert property (run_rise |=> cnt_ff == '0)
    else $error("counter not cleared on run rise");
  stop_hold_a: assert property (!run ##1 !run |-> $stable(cnt_ff))
    else $error("counter moved while stopped");
  pause_hold_a: assert property (pau && !run_rise |=> cnt_ff == $past(cnt_ff))
    else $error("counter moved while paused");
  period_clear_a: assert property (counting && clr |=> cnt_ff == '0)
    else $error("counter not cleared on selected match");
  pulse_a_a: assert property (hit_a |=> match_a_ff ##1 (match_a_ff == $past(hit_a)))
    else $error("compare A pulse wrong");
  cmp_high_a: assert property (mode == TMR_MODE_CMP && hit_a && func == 2'b10 && !run_rise
                               |=> lvl_ff)
    else $error("drive-high action missed");
  run_init_a: assert property (mode == TMR_MODE_CMP && run_rise
                               |=> lvl_ff == $past(c1_ff[TMR_C1_INIT]))
    else $error("initial level not restored");
  timer_oe_a: assert property (mode == TMR_MODE_TMR ##1 mode == TMR_MODE_TMR |-> !oe_ff)
    else $error("pin driven in timer mode");
  hi_latch_a: assert property (acc && !we && idx == TMR_IDX_CNT_HI
                               |=> buf_ff == $past(cnt16[7:0]))
    else $error("low byte not latched on high read");
  hi_load_a: assert property (acc && we && idx == TMR_IDX_CMPA_HI
                              |=> ccra16[7:0] == $past(buf_ff))
    else $error("buffer not moved on high write");

  run_rise_c: cover property (run_rise ##[1:50] hit_a);
  p_clear_c:  cover property (hit_p && clr);
  capture_c:  cover property (cap_evt);
  pulse_c:    cover property (mode == TMR_MODE_PWM && func == 2'b11 && pulse_ff ##1 !pulse_ff);
endmodule

module tmr_top (
  input  wire logic                  core_clk,
  input  wire logic                  rst_b,
  input  wire tmr_pkg::tmr_wb_req_t  wb_req,
  output logic [31:0]                wb_dat_r_ff,
  output logic                       wb_ack_ff,
  input  wire logic                  high_clk_tick,
  input  wire logic                  sub_clk_pin,
  input  wire logic [1:0]            ext_clk_pin,
  input  wire logic [1:0]            cap_pin,
  output logic [1:0]                 wave_out,
  output logic [1:0]                 wave_oe,
  output logic [1:0]                 match_a_pulse,
  output logic [1:0]                 match_p_pulse
);
  import tmr_pkg::*;

  logic [1:0]  sys_div_ff;
  logic [5:0]  high_div_ff;
  logic        sub_s1_ff, sub_s2_ff, sub_s3_ff;
  tmr_ticks_t  ticks;
  logic        acc, mapped, inst, wr_ok;
  logic [2:0]  idx;
  logic [7:0]  rdat [2];
  logic [1:0]  acc_ch;

  // prescalers; high clock arrives as a one-cycle enable from same-domain logic
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sys_div_ff  <= 2'h0;
      high_div_ff <= 6'h00;
      {sub_s1_ff, sub_s2_ff, sub_s3_ff} <= 3'h0;
    end else begin
      sys_div_ff <= sys_div_ff + 2'h1;
      if (high_clk_tick)
        high_div_ff <= high_div_ff + 6'h01;
      {sub_s1_ff, sub_s2_ff, sub_s3_ff} <= {sub_clk_pin, sub_s1_ff, sub_s2_ff};
    end
  end

  assign ticks.sys4   = (sys_div_ff == 2'(TMR_SYS_DIV - 1));
  assign ticks.sys    = 1'b1;
  assign ticks.high16 = high_clk_tick && (high_div_ff[3:0] == 4'(TMR_HIGH_DIV_A - 1));
  assign ticks.high64 = high_clk_tick && (high_div_ff == 6'(TMR_HIGH_DIV_B - 1));
  assign ticks.sub    = sub_s2_ff & ~sub_s3_ff;

  // one access per request, done on the edge that raises ack
  assign acc    = wb_req.cyc & wb_req.stb & ~wb_ack_ff;
  assign inst   = wb_req.adr[TMR_ADR_INST_BIT];
  assign idx    = wb_req.adr[TMR_ADR_IDX_LSB +: 3];
  assign mapped = (wb_req.adr[TMR_ADR_TOP_LSB +: 2] == 2'h0) && (wb_req.adr[1:0] == 2'h0) &&
                  (idx <= TMR_IDX_PERIOD) && (inst || idx != TMR_IDX_PERIOD);
  // a write without byte lane 0 is acked but must not fall through as a latching read
  assign wr_ok  = ~wb_req.we | wb_req.sel[0];
  assign acc_ch = {acc & mapped & wr_ok & inst, acc & mapped & wr_ok & ~inst};

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      wb_ack_ff   <= 1'b0;
      wb_dat_r_ff <= TMR_RD_NONE;
    end else begin
      wb_ack_ff   <= acc;
      // unmapped addresses are acknowledged and read as zero
      wb_dat_r_ff <= (acc && mapped && !wb_req.we) ? {24'h000000, rdat[inst]} : TMR_RD_NONE;
    end
  end

  // instance 0 narrow counter with period code in control zero, instance 1 wide
  for (genvar g = 0; g < 2; g++) begin : g_ch
    tmr_chan #(
      .CW     (g == 0 ? 10 : 16),
      .PW     (g == 0 ? 3 : 8),
      .HAS_RP (g != 0)
    ) u_ch (
      .core_clk   (core_clk),
      .rst_b      (rst_b),
      .ticks      (ticks),
      .ext_pin    (ext_clk_pin[g]),
      .cap_pin    (cap_pin[g]),
      .acc        (acc_ch[g]),
      .we         (wb_req.we & wb_req.sel[0]),
      .idx        (idx),
      .wdat       (wb_req.dat[7:0]),
      .rdat       (rdat[g]),
      .wave_ff    (wave_out[g]),
      .oe_ff      (wave_oe[g]),
      .match_a_ff (match_a_pulse[g]),
      .match_p_ff (match_p_pulse[g])
    );
  end

  ack_once_a: assert property (@(posedge core_clk) disable iff (!rst_b)
                               wb_ack_ff |=> !wb_ack_ff)
    else $error("ack held two cycles");
endmodule

// File: bench/tmr_pin_model.sv
// far-side pin model: external count clock bursts and capture level
`timescale 1ns/10ps
module tmr_pin_model (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       go,
  input  wire logic [7:0] n_edges,
  input  wire logic       cap_lvl,
  output logic            ext_clk,
  output logic            cap_out
);
  logic [7:0] left_ff;
  logic [1:0] ph_ff;
  // clock stands low between bursts; two cycles a phase so the synchroniser sees each edge
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      left_ff <= 8'h00;
      ph_ff   <= 2'h0;
    end else if (go) begin
      left_ff <= n_edges;
      ph_ff   <= 2'h0;
    end else if (left_ff != 8'h00) begin
      ph_ff <= ph_ff + 2'h1;
      if (ph_ff == 2'h3) begin
        left_ff <= left_ff - 8'h01;
      end
    end
  end
  always_ff @(posedge core_clk) begin
    cap_out <= rst_b & cap_lvl;
  end
  assign ext_clk = (left_ff != 8'h00) && ph_ff[1];
endmodule

// File: bench/test_tmr_top.sv
// self-checking bench for the two-instance timer block
`timescale 1ns/10ps
module test_tmr_top;
  import tmr_pkg::*;
  logic        core_clk;
  logic        rst_b;
  tmr_wb_req_t wb_req;
  logic [31:0] wb_dat_r_ff;
  logic        wb_ack_ff;
  logic        high_clk_tick;
  logic        sub_clk_pin;
  logic [2:0]  sub_div;
  logic        ext_clk;
  logic        cap_out;
  logic        go;
  logic [7:0]  n_edges;
  logic        cap_lvl;
  logic [1:0]  wave_out;
  logic [1:0]  wave_oe;
  logic [1:0]  match_a_pulse;
  logic [1:0]  match_p_pulse;
  int          num_errors;
  int          checked;

  tmr_top u_tmr_top (.core_clk(core_clk), .rst_b(rst_b), .wb_req(wb_req),
    .wb_dat_r_ff(wb_dat_r_ff), .wb_ack_ff(wb_ack_ff), .high_clk_tick(high_clk_tick),
    .sub_clk_pin(sub_clk_pin), .ext_clk_pin({ext_clk, ext_clk}), .cap_pin({cap_out, cap_out}),
    .wave_out(wave_out), .wave_oe(wave_oe), .match_a_pulse(match_a_pulse),
    .match_p_pulse(match_p_pulse));
  tmr_pin_model u_tmr_pin_model (.core_clk(core_clk), .rst_b(rst_b), .go(go),
    .n_edges(n_edges), .cap_lvl(cap_lvl), .ext_clk(ext_clk), .cap_out(cap_out));

  always #12.5 core_clk = ~core_clk;
  // high tick every second cycle, sub clock rises every eighth
  always @(posedge core_clk) begin
    high_clk_tick <= ~high_clk_tick;
    sub_div <= sub_div + 3'h1;
    sub_clk_pin <= sub_div[2];
  end

  task automatic end_sim();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [15:0] q);
    int i;
    i = 0;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'h1, dat: {24'h0, d}};
    do begin
      @(posedge core_clk);
      i++;
    end while (wb_ack_ff !== 1'b1 && i < 50);
    if (wb_ack_ff !== 1'b1) begin
      num_errors++;
      end_sim();
    end else begin
      q = {8'h00, wb_dat_r_ff[7:0]};
      wb_req <= '0;
      @(posedge core_clk);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [15:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] q);
    bus(1'b0, a, 8'h00, q);
  endtask

  // high byte first: that read latches the low byte into the buffer
  task automatic rd16(input logic [7:0] hi, output logic [15:0] v);
    logic [15:0] h;
    logic [15:0] l;
    rd(hi, h);
    rd(hi - 8'h04, l);
    v = {h[7:0], l[7:0]};
  endtask

  function automatic logic [7:0] ad(input logic i, input logic [2:0] x);
    return {2'b00, i, x, 2'b00};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wait_match(input logic is_p, input logic i, input int lim, output int n);
    logic s;
    n = 0;
    do begin
      @(posedge core_clk);
      s = is_p ? match_p_pulse[i] : match_a_pulse[i];
      n++;
    end while (s !== 1'b1 && n < lim);
    if (s !== 1'b1) begin
      num_errors++;
      end_sim();
    end
  endtask

  task automatic t_reset();
    logic [15:0] q;
    for (int k = 0; k < 16; k++) begin
      rd(ad(k[3], k[2:0]), q);
      chk("reset value", 16'h0000, q);
    end
  endtask

  task automatic t_cmpa();
    logic [15:0] q;
    wr(ad(1, 4), 8'h34);
    wr(ad(1, 5), 8'h12);
    rd(ad(1, 5), q);
    chk("wide a high", 16'h0012, q);
    rd(ad(1, 4), q);
    chk("wide a low", 16'h0034, q);
    wr(ad(1, 4), 8'h56);
    rd(ad(1, 5), q);
    rd(ad(1, 4), q);
    chk("buffered low", 16'h0034, q);
    wr(ad(0, 4), 8'hAB);
    wr(ad(0, 5), 8'hFF);
    rd16(ad(0, 5), q);
    chk("narrow a", 16'h03AB, q);
  endtask

  task automatic t_count();
    logic [15:0] v1;
    logic [15:0] v2;
    wr(ad(0, 1), 8'hC0);
    wr(ad(0, 0), 8'h18);
    tick(800);
    wr(ad(0, 0), 8'h98);
    rd16(ad(0, 3), v1);
    chk("narrow high", 16'h0000, {8'h00, v1[15:8] & 8'hFC});
    tick(20);
    rd16(ad(0, 3), v2);
    chk("paused", v1, v2);
    wr(ad(0, 0), 8'h18);
    tick(10);
    wr(ad(0, 0), 8'h10);
    rd16(ad(0, 3), v2);
    chk("resumed", 16'h0001, {15'h0, v2 > v1});
    tick(20);
    rd16(ad(0, 3), v1);
    chk("held", v2, v1);
    wr(ad(0, 0), 8'h18);
    rd16(ad(0, 3), v1);
    chk("cleared", 16'h0001, {15'h0, v1 < 16'h0010});
    chk("timer oe", 16'h0000, {15'h0, wave_oe[0]});
  endtask

  task automatic t_cmp();
    logic [1:0] f;
    logic       ini;
    logic       e;
    int         n;
    wr(ad(1, 4), 8'h10);
    wr(ad(1, 5), 8'h00);
    for (int k = 0; k < 8; k++) begin
      f = k[2:1];
      ini = k[0];
      wr(ad(1, 0), 8'h10);
      wr(ad(1, 1), {2'b00, f, ini, 3'b001});
      wr(ad(1, 0), 8'h18);
      tick(2);
      chk("initial level", {15'h0, ini}, {15'h0, wave_out[1]});
      chk("cmp oe", 16'h0001, {15'h0, wave_oe[1]});
      wait_match(1'b0, 1'b1, 60, n);
      tick(3);
      e = (f == 2'h0) ? ini : (f == 2'h1) ? 1'b0 : (f == 2'h2) ? 1'b1 : ~ini;
      chk("after match", {15'h0, e}, {15'h0, wave_out[1]});
    end
  endtask

  task automatic t_period(input logic i, input logic [7:0] c0, input logic [15:0] per);
    int n;
    wr(ad(i, 0), 8'h00);
    wr(ad(i, 1), 8'hC0);
    wr(ad(i, 0), c0);
    wait_match(1'b1, i, 40000, n);
    wait_match(1'b1, i, 40000, n);
    chk("period", per, n[15:0]);
  endtask

  task automatic t_ext();
    logic [15:0] v;
    for (int k = 0; k < 2; k++) begin
      wr(ad(1, 0), 8'h00);
      wr(ad(1, 1), 8'hC0);
      wr(ad(1, 0), (k == 1) ? 8'h78 : 8'h68);
      go <= 1'b1;
      n_edges <= 8'h05;
      tick(1);
      go <= 1'b0;
      tick(40);
      wr(ad(1, 0), (k == 1) ? 8'hF8 : 8'hE8);
      rd16(ad(1, 3), v);
      chk("pin edges", 16'h0005, v);
    end
  endtask

  task automatic t_cap();
    logic [1:0]  f;
    logic [15:0] v1;
    logic [15:0] v2;
    for (int k = 0; k < 4; k++) begin
      f = k[1:0];
      wr(ad(1, 0), 8'h00);
      wr(ad(1, 4), 8'h00);
      wr(ad(1, 5), 8'h00);
      wr(ad(1, 1), {2'b01, f, 4'h0});
      wr(ad(1, 0), 8'h18);
      tick(20);
      cap_lvl <= 1'b1;
      tick(10);
      rd16(ad(1, 5), v1);
      chk("rise capture", {15'h0, f == 2'h0 || f == 2'h2}, {15'h0, v1 != 16'h0});
      cap_lvl <= 1'b0;
      tick(10);
      rd16(ad(1, 5), v2);
      chk("fall capture", {15'h0, f == 2'h1 || f == 2'h2}, {15'h0, v2 != v1});
    end
  endtask

  task automatic t_pwm();
    logic [15:0] exp [4];
    int          hi;
    int          lo;
    int          n;
    exp = '{16'h0000, 16'h0100, 16'h0080, 16'h0000};
    wr(ad(0, 4), 8'h40);
    wr(ad(0, 5), 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(ad(0, 0), 8'h01);
      wr(ad(0, 1), {2'b10, k[1:0], 4'h8});
      wr(ad(0, 0), 8'h19);
      tick(4);
      hi = 0;
      lo = 0;
      for (int c = 0; c < 256; c++) begin
        @(posedge core_clk);
        hi += (wave_out[0] === 1'b1);
        lo += (wave_out[0] === 1'b0);
      end
      if (k == 3) begin
        chk("single pulse", 16'h0001, {15'h0, hi > 50 && hi < 66});
      end else begin
        chk("pwm high", exp[k], hi[15:0]);
      end
      chk("pwm known", 16'h0100, hi[15:0] + lo[15:0]);
    end
    // swap: A sets a 384 period, code 1 gives 128 active cycles, then inverted
    wr(ad(0, 0), 8'h01);
    wr(ad(0, 4), 8'h80);
    wr(ad(0, 5), 8'h01);
    wr(ad(0, 1), 8'hAE);
    wr(ad(0, 0), 8'h19);
    tick(4);
    hi = 0;
    for (int c = 0; c < 384; c++) begin
      @(posedge core_clk);
      hi += (wave_out[0] === 1'b1);
    end
    chk("swapped inverted pwm", 16'h0100, hi[15:0]);
    wait_match(1'b0, 1'b0, 500, n);
    wait_match(1'b0, 1'b0, 500, n);
    chk("a match period", 16'h0180, n[15:0]);
  endtask

  initial begin
    core_clk = 1'b0;
    rst_b = 1'b0;
    wb_req = '0;
    high_clk_tick = 1'b0;
    sub_clk_pin = 1'b0;
    sub_div = 3'h0;
    go = 1'b0;
    n_edges = 8'h00;
    cap_lvl = 1'b0;
    num_errors = 0;
    checked = 0;
    tick(4);
    rst_b <= 1'b1;
    t_reset();
    t_cmpa();
    t_count();
    t_cmp();
    t_period(1'b0, 8'h19, 16'h0080);
    t_period(1'b0, 8'h18, 16'h0400);
    wr(ad(1, 6), 8'h01);
    t_period(1'b1, 8'h18, 16'h0100);
    t_period(1'b0, 8'h09, 16'h0200);
    t_period(1'b0, 8'h29, 16'h1000);
    t_period(1'b0, 8'h39, 16'h4000);
    t_period(1'b0, 8'h49, 16'h0400);
    t_period(1'b0, 8'h59, 16'h0400);
    t_ext();
    t_cap();
    t_pwm();
    end_sim();
  end
endmodule
